//--- csu_pkg.sv
// Purpose: shared constants and types for the camera simulator register bank
// Assumes: byte-wide registers at their printed offsets on a plain strobe port
// Notes: offsets 0x10 and 0x24 hold the edge enable and the baud divisor
package csu_pkg;

   // widths
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned CTRL_LINES = 4;
   localparam int unsigned DATA_BITS = 8;

   // register offsets
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_SIM_STAT = 8'h01;
   localparam logic [7:0] ADDR_SIM_CFG = 8'h02;
   localparam logic [7:0] ADDR_RSVD = 8'h05;
   localparam logic [7:0] ADDR_CTRL_LINES = 8'h07;
   localparam logic [7:0] ADDR_SER_BYTE = 8'h0A;
   localparam logic [7:0] ADDR_SER_STAT = 8'h0B;
   localparam logic [7:0] ADDR_SER_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_UTIL2 = 8'h10;
   localparam logic [7:0] ADDR_BAUD_DIV = 8'h24;

   // fixed read value of the command location
   localparam logic [7:0] CMD_READ_VALUE = 8'h02;

   // field positions
   localparam int unsigned CMD_CLR_EDGE_BIT = 4;
   localparam int unsigned CMD_EDGE_RST_BIT = 0;
   localparam int unsigned STAT_HAS_WORDS_BIT = 4;
   localparam int unsigned STAT_FRAME_BIT = 1;
   localparam int unsigned STAT_UNDERRUN_BIT = 0;
   localparam int unsigned CFG_CLEAR_BIT = 3;
   localparam int unsigned UTIL2_EDGE_EN_BIT = 3;
   localparam int unsigned SSTAT_IRQ_BIT = 7;
   localparam int unsigned SSTAT_EDGE_SEEN_BIT = 6;
   localparam int unsigned SSTAT_MASKED_BIT = 4;
   localparam int unsigned SSTAT_TX_RDY_BIT = 1;
   localparam int unsigned SSTAT_RX_RDY_BIT = 0;
   localparam int unsigned SCTRL_BAUD_HI = 7;
   localparam int unsigned SCTRL_BAUD_LO = 6;
   localparam int unsigned SCTRL_RX_CLR_BIT = 5;
   localparam int unsigned SCTRL_GLOB_BIT = 4;
   localparam int unsigned SCTRL_TX_IRQ_BIT = 3;
   localparam int unsigned SCTRL_RX_IRQ_BIT = 2;
   localparam int unsigned SCTRL_TX_EN_BIT = 1;
   localparam int unsigned SCTRL_RX_EN_BIT = 0;

   // serial rates and divisor relation
   localparam int unsigned BAUD_SEL0 = 9600;
   localparam int unsigned BAUD_SEL1 = 19200;
   localparam int unsigned BAUD_SEL2 = 38400;
   localparam int unsigned BAUD_SEL3 = 115200;
   localparam int unsigned REF_HZ = 20_000_000;
   localparam int unsigned OVERSAMPLE = 16;
   localparam int unsigned DIV_OFFSET = 2;

   // serial engine states, gray along idle-start-data-stop
   typedef enum logic [1:0] {
      SER_IDLE = 2'h0,
      SER_START = 2'h1,
      SER_DATA = 2'h3,
      SER_STOP = 2'h2
   } csu_ser_state_type;

   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } csu_bus_req_type;

   // levels and events from the simulator data path
   typedef struct packed {
      logic buffer_has_words;
      logic underrun_event;
      logic frame_active;
      logic [CTRL_LINES-1:0] cam_ctrl;
   } csu_sim_in_type;

   // all state of the register bank
   typedef struct packed {
      logic cfg_clear;
      logic edge_irq_enable;
      logic [DATA_W-1:0] ser_ctrl;
      logic [DATA_W-1:0] baud_div;
      logic frame_q;
      logic edge_seen;
      logic underrun_seen;
      logic [DATA_W-1:0] rdata;
      csu_ser_state_type tx_state;
      logic tx_hold_full;
      logic [DATA_W-1:0] tx_hold;
      logic [DATA_W-1:0] tx_shift;
      logic [CNT_W-1:0] tx_cnt;
      logic [2:0] tx_bits;
      logic tx_space;
      csu_ser_state_type rx_state;
      logic [DATA_W-1:0] rx_shift;
      logic [CNT_W-1:0] rx_cnt;
      logic [2:0] rx_bits;
      logic [DATA_W-1:0] rx_data;
      logic rx_ready;
   } csu_state_type;

endpackage

//--- csu_regs.sv
// Purpose: host register bank of a camera output simulator with a byte serial port
// Assumes: one clock, inputs synchronous to it, read data one cycle after the read strobe
// Notes: unused bits read zero; serial format is 8N1 at the selected rate
// Function
// R1: unused bits read zero; software writes them as zero
// R2: command location is write-only and always reads 0x02
// R3: command bit 4 write clears the frame-edge flag once
// R4: command bit 0 write resets the frame-edge interrupt state once
// R5: status bit 4 shows the output buffer holds data
// R6: status bit 1 shows frame-active is being driven
// R7: status bit 0 shows an underrun of stream data
// R8: config bit 3 holds the simulator cleared until software clears it
// R9: offset 0x05 reads zero and ignores writes
// R10: readback bits 3-0 show the four camera-control lines
// R11: serial byte write transmits; read returns last received byte
// R12: serial status bit 6 sets on frame-active rise until cleared
// R13: serial status bit 4 is edge flag AND edge enable
// R14: serial status bit 7 is global enable AND any enabled source
// R15: serial status bit 1 shows transmit holding register free
// R16: serial status bit 0 shows a received character waiting
// R17: with divisor zero, control bits 7-6 pick 9600 to 115200
// R18: serial control bit 5 write clears the receive-ready flag
// R19: serial control bit 4 is the global interrupt enable
// R20: serial control bit 3 enables the transmit-empty source
// R21: serial control bit 2 enables the receive-full source
// R22: serial control bits 1 and 0 enable transmitter and receiver
// R23: edge interrupt enable sits in bit 3 at offset 0x10
// R24: nonzero divisor sets rate from 20 MHz reference over 16(div+2)
// R25: characters are one start, eight data LSB first, one stop
// R26: all register bits reset to zero; interrupt starts deasserted
`timescale 1ns/100ps
module csu_regs import csu_pkg::*; #(
   parameter int unsigned CLK_HZ = 250_000_000
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire csu_bus_req_type bus_req,
   output logic [DATA_W-1:0] reg_rdata,
   // simulator data path
   input wire csu_sim_in_type sim_in,
   output logic sim_clear,
   output logic irq_request,
   // serial link to the frame grabber
   input wire logic serial_from_grabber,
   output logic serial_to_grabber
);

   // cycles per reference tick of the divisor relation
   localparam int unsigned REF_TICK_CYC = CLK_HZ / (REF_HZ / OVERSAMPLE);

   // refuse clock rates whose slowest bit does not fit the counter
   if (CLK_HZ / BAUD_SEL0 >= (1 << CNT_W) || REF_TICK_CYC * (255 + DIV_OFFSET) >= (1 << CNT_W)
       || CLK_HZ / BAUD_SEL3 < 2) begin : g_bad_clk
      $error("csu_regs: CLK_HZ out of range for the bit counter");
   end

   // bit period in clock cycles from rate select and divisor
   function automatic logic [CNT_W-1:0] bit_cycles(input logic [1:0] sel, input logic [DATA_W-1:0] div);
      int unsigned cyc;
      cyc = 0;
      if (div != '0) begin
         cyc = REF_TICK_CYC * (int'(div) + DIV_OFFSET); // R24
      end else begin
         case (sel) // R17
            2'h0: cyc = CLK_HZ / BAUD_SEL0;
            2'h1: cyc = CLK_HZ / BAUD_SEL1;
            2'h2: cyc = CLK_HZ / BAUD_SEL2;
            default: cyc = CLK_HZ / BAUD_SEL3;
         endcase
      end
      return cyc[CNT_W-1:0];
   endfunction

   csu_state_type st_ff;
   csu_state_type nxt_st;
   logic rise;
   logic wr_cmd;
   logic wr_ctrl;
   logic masked_edge_flag;
   logic irq_request_flag;
   logic rx_done;
   logic [CNT_W-1:0] period;
   logic [DATA_W-1:0] rd_val;

   // interrupt sources and the combined request
   always_comb begin
      masked_edge_flag = st_ff.edge_seen & st_ff.edge_irq_enable; // R13 R23
      irq_request_flag = st_ff.ser_ctrl[SCTRL_GLOB_BIT] & (masked_edge_flag // R14 R19
         | (~st_ff.tx_hold_full & st_ff.ser_ctrl[SCTRL_TX_IRQ_BIT]) // R20
         | (st_ff.rx_ready & st_ff.ser_ctrl[SCTRL_RX_IRQ_BIT])); // R21
   end

   // next-state logic of the whole bank
   always_comb begin
      nxt_st = st_ff;
      period = bit_cycles(st_ff.ser_ctrl[SCTRL_BAUD_HI:SCTRL_BAUD_LO], st_ff.baud_div);
      rise = sim_in.frame_active & ~st_ff.frame_q;
      wr_cmd = bus_req.wr && bus_req.addr == ADDR_CMD;
      wr_ctrl = bus_req.wr && bus_req.addr == ADDR_SER_CTRL;
      rx_done = 1'b0;
      rd_val = '0;
      nxt_st.frame_q = sim_in.frame_active;

      // plain register writes; reserved offset falls through
      if (bus_req.wr) begin
         case (bus_req.addr)
            ADDR_SIM_CFG: nxt_st.cfg_clear = bus_req.wdata[CFG_CLEAR_BIT]; // R8
            ADDR_UTIL2: nxt_st.edge_irq_enable = bus_req.wdata[UTIL2_EDGE_EN_BIT]; // R23
            ADDR_BAUD_DIV: nxt_st.baud_div = bus_req.wdata; // R24
            ADDR_SER_CTRL: begin
               nxt_st.ser_ctrl = bus_req.wdata;
               nxt_st.ser_ctrl[SCTRL_RX_CLR_BIT] = 1'b0; // clear bit acts, is not stored
            end
            default: nxt_st.ser_ctrl = st_ff.ser_ctrl; // R9
         endcase
      end

      // frame-edge flag: edge wins over the command clears
      if (st_ff.cfg_clear) begin
         nxt_st.edge_seen = 1'b0; // R8
      end else if (rise) begin
         nxt_st.edge_seen = 1'b1; // R12
      end else if (wr_cmd && (bus_req.wdata[CMD_CLR_EDGE_BIT] | bus_req.wdata[CMD_EDGE_RST_BIT])) begin
         nxt_st.edge_seen = 1'b0; // R3 R4
      end

      // sticky underrun, dropped while the simulator is held clear
      if (st_ff.cfg_clear) begin
         nxt_st.underrun_seen = 1'b0; // R8
      end else if (sim_in.underrun_event) begin
         nxt_st.underrun_seen = 1'b1; // R7
      end

      // transmitter: holding register feeds the shifter
      if (bus_req.wr && bus_req.addr == ADDR_SER_BYTE && !st_ff.tx_hold_full) begin
         nxt_st.tx_hold = bus_req.wdata; // R11
         nxt_st.tx_hold_full = 1'b1;
      end
      if (st_ff.tx_cnt != '0) begin
         nxt_st.tx_cnt = st_ff.tx_cnt - 1'b1;
      end
      case (st_ff.tx_state)
         SER_IDLE: begin
            nxt_st.tx_space = 1'b0;
            if (st_ff.ser_ctrl[SCTRL_TX_EN_BIT] && st_ff.tx_hold_full) begin // R22
               nxt_st.tx_shift = st_ff.tx_hold;
               nxt_st.tx_hold_full = 1'b0; // R15
               nxt_st.tx_state = SER_START;
               nxt_st.tx_cnt = period - 1'b1;
               nxt_st.tx_space = 1'b1; // R25
            end
         end
         SER_START: begin
            if (st_ff.tx_cnt == '0) begin
               nxt_st.tx_state = SER_DATA;
               nxt_st.tx_bits = '0;
               nxt_st.tx_cnt = period - 1'b1;
               nxt_st.tx_space = ~st_ff.tx_shift[0]; // R25
            end
         end
         SER_DATA: begin
            if (st_ff.tx_cnt == '0) begin
               nxt_st.tx_cnt = period - 1'b1;
               if (st_ff.tx_bits == 3'(DATA_BITS - 1)) begin
                  nxt_st.tx_state = SER_STOP;
                  nxt_st.tx_space = 1'b0; // R25
               end else begin
                  nxt_st.tx_shift = st_ff.tx_shift >> 1;
                  nxt_st.tx_bits = st_ff.tx_bits + 1'b1;
                  nxt_st.tx_space = ~st_ff.tx_shift[1];
               end
            end
         end
         SER_STOP: begin
            if (st_ff.tx_cnt == '0) begin
               nxt_st.tx_state = SER_IDLE;
            end
         end
         default: nxt_st.tx_state = SER_IDLE;
      endcase
      // disabled transmitter drops any character in flight
      if (!st_ff.ser_ctrl[SCTRL_TX_EN_BIT]) begin
         nxt_st.tx_state = SER_IDLE; // R22
         nxt_st.tx_space = 1'b0;
         nxt_st.tx_cnt = '0;
      end

      // receiver: start found, checked at mid-bit, then bit centres
      if (st_ff.rx_cnt != '0) begin
         nxt_st.rx_cnt = st_ff.rx_cnt - 1'b1;
      end
      case (st_ff.rx_state)
         SER_IDLE: begin
            if (st_ff.ser_ctrl[SCTRL_RX_EN_BIT] && !serial_from_grabber) begin // R22
               nxt_st.rx_state = SER_START;
               nxt_st.rx_cnt = period >> 1;
            end
         end
         SER_START: begin
            if (st_ff.rx_cnt == '0) begin
               nxt_st.rx_state = serial_from_grabber ? SER_IDLE : SER_DATA;
               nxt_st.rx_bits = '0;
               nxt_st.rx_cnt = period - 1'b1;
            end
         end
         SER_DATA: begin
            if (st_ff.rx_cnt == '0) begin
               nxt_st.rx_shift = {serial_from_grabber, st_ff.rx_shift[DATA_W-1:1]}; // R25
               nxt_st.rx_cnt = period - 1'b1;
               nxt_st.rx_bits = st_ff.rx_bits + 1'b1;
               if (st_ff.rx_bits == 3'(DATA_BITS - 1)) begin
                  nxt_st.rx_state = SER_STOP;
               end
            end
         end
         SER_STOP: begin
            if (st_ff.rx_cnt == '0) begin
               nxt_st.rx_state = SER_IDLE;
               rx_done = serial_from_grabber; // framing error discards the byte
            end
         end
         default: nxt_st.rx_state = SER_IDLE;
      endcase
      if (!st_ff.ser_ctrl[SCTRL_RX_EN_BIT]) begin
         nxt_st.rx_state = SER_IDLE; // R22
         nxt_st.rx_cnt = '0;
      end

      // receive-ready: held clear first, then a new character wins over the software clear
      if (rx_done) begin
         nxt_st.rx_data = st_ff.rx_shift; // R11
      end
      if (st_ff.cfg_clear) begin
         nxt_st.rx_ready = 1'b0; // R8
      end else if (rx_done) begin
         nxt_st.rx_ready = 1'b1; // R16
      end else if (wr_ctrl && bus_req.wdata[SCTRL_RX_CLR_BIT]) begin
         nxt_st.rx_ready = 1'b0; // R18
      end

      // read multiplexer, answer stands in the next cycle
      if (bus_req.rd) begin
         case (bus_req.addr)
            ADDR_CMD: rd_val = CMD_READ_VALUE; // R2
            ADDR_SIM_STAT: begin
               rd_val[STAT_HAS_WORDS_BIT] = sim_in.buffer_has_words & ~st_ff.cfg_clear; // R5
               rd_val[STAT_FRAME_BIT] = sim_in.frame_active; // R6
               rd_val[STAT_UNDERRUN_BIT] = st_ff.underrun_seen; // R7
            end
            ADDR_SIM_CFG: rd_val[CFG_CLEAR_BIT] = st_ff.cfg_clear;
            ADDR_CTRL_LINES: rd_val[CTRL_LINES-1:0] = sim_in.cam_ctrl; // R10
            ADDR_SER_BYTE: rd_val = st_ff.rx_data; // R11
            ADDR_SER_STAT: begin
               rd_val[SSTAT_IRQ_BIT] = irq_request_flag; // R14
               rd_val[SSTAT_EDGE_SEEN_BIT] = st_ff.edge_seen; // R12
               rd_val[SSTAT_MASKED_BIT] = masked_edge_flag; // R13
               rd_val[SSTAT_TX_RDY_BIT] = ~st_ff.tx_hold_full; // R15
               rd_val[SSTAT_RX_RDY_BIT] = st_ff.rx_ready; // R16
            end
            ADDR_SER_CTRL: rd_val = st_ff.ser_ctrl;
            ADDR_UTIL2: rd_val[UTIL2_EDGE_EN_BIT] = st_ff.edge_irq_enable;
            ADDR_BAUD_DIV: rd_val = st_ff.baud_div;
            default: rd_val = '0; // R1 R9
         endcase
      end
      nxt_st.rdata = rd_val;
   end

   // state register, all zero at reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0; // R26
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs
   assign reg_rdata = st_ff.rdata;
   assign sim_clear = st_ff.cfg_clear; // R8
   assign irq_request = irq_request_flag; // R14
   assign serial_to_grabber = ~st_ff.tx_space; // R25

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_rise;
      sim_in.frame_active && !st_ff.frame_q && !st_ff.cfg_clear;
   endsequence

   sequence s_read(logic [7:0] a);
      bus_req.rd && bus_req.addr == a;
   endsequence

   sequence s_cmd_clear;
      bus_req.wr && bus_req.addr == ADDR_CMD && bus_req.wdata[CMD_CLR_EDGE_BIT]
         && !sim_in.frame_active && !st_ff.cfg_clear;
   endsequence

   sequence s_cmd_reset;
      bus_req.wr && bus_req.addr == ADDR_CMD && bus_req.wdata[CMD_EDGE_RST_BIT]
         && !(sim_in.frame_active && !st_ff.frame_q);
   endsequence

   a_cmd_read_const: assert property (s_read(ADDR_CMD) |=> reg_rdata == CMD_READ_VALUE) // R2
      else $error("command read did not return its constant");
   a_rsvd_read_zero: assert property (s_read(ADDR_RSVD) |=> reg_rdata == '0) // R9
      else $error("reserved offset read not zero");
   a_edge_sets_flag: assert property (s_rise ##1 (bus_req.rd && bus_req.addr == ADDR_SER_STAT)
      |=> reg_rdata[SSTAT_EDGE_SEEN_BIT]) // R12
      else $error("frame edge did not set the edge flag");
   a_edge_clear_cmd: assert property (s_cmd_clear |=> !st_ff.edge_seen) // R3
      else $error("clear command left the edge flag set");
   a_edge_reset_cmd: assert property (s_cmd_reset |=> !st_ff.edge_seen) // R4
      else $error("reset command left the edge flag set");
   a_masked_edge_read: assert property (s_read(ADDR_SER_STAT)
      |=> reg_rdata[SSTAT_MASKED_BIT] == ($past(st_ff.edge_seen) && $past(st_ff.edge_irq_enable))) // R13
      else $error("masked edge bit wrong");
   a_irq_needs_global: assert property (!st_ff.ser_ctrl[SCTRL_GLOB_BIT] |-> !irq_request) // R19
      else $error("interrupt without global enable");
   a_irq_edge_path: assert property (st_ff.ser_ctrl[SCTRL_GLOB_BIT] && masked_edge_flag |-> irq_request) // R14
      else $error("enabled edge raised no interrupt");
   a_clear_holds: assert property (st_ff.cfg_clear [*2] |-> !st_ff.edge_seen && !st_ff.underrun_seen
      && !st_ff.rx_ready) // R8
      else $error("held clear left state bits set");
   a_rx_flag_clear: assert property (wr_ctrl && bus_req.wdata[SCTRL_RX_CLR_BIT] && !rx_done
      |=> !st_ff.rx_ready) // R18
      else $error("receive-ready not cleared");
   a_tx_hold_take: assert property (bus_req.wr && bus_req.addr == ADDR_SER_BYTE && !st_ff.tx_hold_full
      |=> st_ff.tx_hold_full && st_ff.tx_hold == $past(bus_req.wdata)) // R15
      else $error("transmit byte not held");
   a_tx_start_bit: assert property (st_ff.tx_state == SER_IDLE ##1 st_ff.tx_state == SER_START
      |-> !serial_to_grabber [*2]) // R25
      else $error("start bit not low");
   a_mode_readback: assert property (s_read(ADDR_CTRL_LINES)
      |=> reg_rdata == DATA_W'($past(sim_in.cam_ctrl))) // R10
      else $error("camera-control readback wrong");
   a_tx_disabled_idle: assert property (!st_ff.ser_ctrl[SCTRL_TX_EN_BIT] ##1 !st_ff.ser_ctrl[SCTRL_TX_EN_BIT]
      |-> st_ff.tx_state == SER_IDLE && serial_to_grabber) // R22
      else $error("disabled transmitter active");

endmodule

//--- csu_grabber_model.sv
// Purpose: frame grabber end of the serial link, sends and collects 8N1 characters
// Assumes: bench sets bit_p, the bit period in clock cycles, before each character
// Notes: framing faults on received characters are counted in bad_frames
`timescale 1ns/100ps
module csu_grabber_model (
   // clock
   input wire logic clk,
   // serial lines
   input wire logic serial_to_grabber,
   output logic serial_from_grabber
);
   int bit_p = 21;
   int bad_frames = 0;
   logic [7:0] got_q[$];

   // line rests high between characters
   initial serial_from_grabber = 1'b1;

   // start low, eight data bits lsb first, stop high; stop level doubles as idle
   task automatic send_char(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         serial_from_grabber <= frame[i];
         repeat (bit_p - 1) @(posedge clk);
      end
   endtask

   // sample each bit of an incoming character at its middle
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge serial_to_grabber);
         repeat (bit_p / 2) @(posedge clk);
         if (serial_to_grabber !== 1'b0) bad_frames++;
         for (int i = 0; i < 8; i++) begin
            repeat (bit_p) @(posedge clk);
            b[i] = serial_to_grabber;
         end
         repeat (bit_p) @(posedge clk);
         if (serial_to_grabber !== 1'b1) bad_frames++;
         got_q.push_back(b);
      end
   end
endmodule

//--- tb_top.sv
// Purpose: self-checking bench for the simulator register bank
// Assumes: CLK_HZ lowered so that serial bit periods stay short
// Notes: every register access leaves one idle cycle after its strobe
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_top import csu_pkg::*;;
   logic clk;
   logic resetn;
   csu_bus_req_type bus_req;
   logic [7:0] reg_rdata;
   csu_sim_in_type sim_in;
   logic sim_clear;
   logic irq_request;
   logic ser_in;
   logic ser_out;
   int n_errors;
   int checks;
   int cycles;
   int ptab[5] = '{260, 130, 65, 21, 8};

   // design and far end
   csu_regs #(.CLK_HZ(2_500_000)) dut (.clk(clk), .resetn(resetn), .bus_req(bus_req),
      .reg_rdata(reg_rdata), .sim_in(sim_in), .sim_clear(sim_clear), .irq_request(irq_request),
      .serial_from_grabber(ser_in), .serial_to_grabber(ser_out));
   csu_grabber_model grabber (.clk(clk), .serial_to_grabber(ser_out), .serial_from_grabber(ser_in));

   // 250 MHz clock
   initial clk = 1'b0;
   always #2 clk = ~clk;

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // hang guard well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         close_out();
      end
   end

   // one write strobe cycle
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask

   // one read strobe cycle, data compared in the following cycle
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   // main sequence
   initial begin
      resetn = 1'b0;
      bus_req = '0;
      sim_in = '0;
      n_errors = 0;
      checks = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rd_chk(ADDR_SIM_STAT, 8'h00);
      rd_chk(ADDR_SIM_CFG, 8'h00);
      rd_chk(ADDR_SER_CTRL, 8'h00);
      rd_chk(ADDR_UTIL2, 8'h00);
      rd_chk(ADDR_BAUD_DIV, 8'h00);
      rd_chk(ADDR_SER_STAT, 8'h02);
      `CHK(irq_request, 1'b0)
      $display("done: reset values");
      // fixed, reserved, unmapped and live readback locations
      reg_wr(ADDR_CMD, 8'h11);
      rd_chk(ADDR_CMD, CMD_READ_VALUE);
      reg_wr(ADDR_RSVD, 8'hFF);
      rd_chk(ADDR_RSVD, 8'h00);
      rd_chk(8'h33, 8'h00);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         sim_in.cam_ctrl <= 4'(i);
         rd_chk(ADDR_CTRL_LINES, 8'(i));
      end
      $display("done: fixed locations");
      // buffer, underrun and clear bit
      @(posedge clk);
      sim_in.buffer_has_words <= 1'b1;
      rd_chk(ADDR_SIM_STAT, 8'h10);
      @(posedge clk);
      sim_in.underrun_event <= 1'b1;
      @(posedge clk);
      sim_in.underrun_event <= 1'b0;
      rd_chk(ADDR_SIM_STAT, 8'h11);
      reg_wr(ADDR_SIM_CFG, 8'h08);
      #1 `CHK(sim_clear, 1'b1)
      rd_chk(ADDR_SIM_CFG, 8'h08);
      rd_chk(ADDR_SIM_STAT, 8'h00);
      reg_wr(ADDR_SIM_CFG, 8'h00);
      #1 `CHK(sim_clear, 1'b0)
      rd_chk(ADDR_SIM_STAT, 8'h10);
      $display("done: status and clear");
      // frame-active edge flag, its mask, the request and both clears
      @(posedge clk);
      sim_in.frame_active <= 1'b1;
      rd_chk(ADDR_SIM_STAT, 8'h12);
      rd_chk(ADDR_SER_STAT, 8'h42);
      reg_wr(ADDR_UTIL2, 8'h08);
      rd_chk(ADDR_UTIL2, 8'h08);
      rd_chk(ADDR_SER_STAT, 8'h52);
      reg_wr(ADDR_SER_CTRL, 8'h10);
      rd_chk(ADDR_SER_STAT, 8'hD2);
      `CHK(irq_request, 1'b1)
      reg_wr(ADDR_CMD, 8'h10);
      rd_chk(ADDR_SER_STAT, 8'h02);
      @(posedge clk);
      sim_in.frame_active <= 1'b0;
      @(posedge clk);
      sim_in.frame_active <= 1'b1;
      rd_chk(ADDR_SER_STAT, 8'hD2);
      reg_wr(ADDR_CMD, 8'h01);
      rd_chk(ADDR_SER_STAT, 8'h02);
      `CHK(irq_request, 1'b0)
      reg_wr(ADDR_SER_CTRL, 8'h18);
      #1 `CHK(irq_request, 1'b1)
      reg_wr(ADDR_SER_CTRL, 8'h08);
      #1 `CHK(irq_request, 1'b0)
      $display("done: edge flag and request");
      // transmit held while disabled, then two bytes back to back
      reg_wr(ADDR_SER_CTRL, 8'hC0);
      reg_wr(ADDR_SER_BYTE, 8'hA5);
      repeat (63) @(posedge clk);
      `CHK(ser_out, 1'b1)
      rd_chk(ADDR_SER_STAT, 8'h00);
      reg_wr(ADDR_SER_CTRL, 8'hC2);
      reg_wr(ADDR_SER_BYTE, 8'h3C);
      rd_chk(ADDR_SER_STAT, 8'h00);
      repeat (525) @(posedge clk);
      `CHK(grabber.got_q.size(), 2)
      `CHK(grabber.got_q[0], 8'hA5)
      `CHK(grabber.got_q[1], 8'h3C)
      `CHK(grabber.bad_frames, 0)
      $display("done: transmit");
      // every rate select, then a divisor override
      for (int k = 0; k < 5; k++) begin
         grabber.bit_p = ptab[k];
         if (k == 4) reg_wr(ADDR_BAUD_DIV, 8'h02);
         reg_wr(ADDR_SER_CTRL, {k[1:0], 6'h02});
         reg_wr(ADDR_SER_BYTE, 8'h5A ^ 8'(k));
         repeat (10 * ptab[k] + 10) @(posedge clk);
         `CHK(grabber.got_q[$], 8'h5A ^ 8'(k))
      end
      reg_wr(ADDR_BAUD_DIV, 8'h00);
      $display("done: rates");
      // receive with its interrupt, ready clear, then receiver disabled
      grabber.bit_p = 21;
      reg_wr(ADDR_SER_CTRL, 8'hD5);
      grabber.send_char(8'hC3);
      repeat (42) @(posedge clk);
      rd_chk(ADDR_SER_STAT, 8'h83);
      `CHK(irq_request, 1'b1)
      rd_chk(ADDR_SER_BYTE, 8'hC3);
      reg_wr(ADDR_SER_CTRL, 8'hF5);
      rd_chk(ADDR_SER_CTRL, 8'hD5);
      rd_chk(ADDR_SER_STAT, 8'h02);
      reg_wr(ADDR_SER_CTRL, 8'hC4);
      grabber.send_char(8'h77);
      repeat (42) @(posedge clk);
      rd_chk(ADDR_SER_STAT, 8'h02);
      $display("done: receive");
      close_out();
   end
endmodule
